// [sarb_ord_fifo.sv]
// Order queue: which master owns each read still in flight
`timescale 1ns/1ps
`default_nettype none
module sarb_ord_fifo #(
   parameter int DEPTH = 5,
   parameter int IW    = 1,
   parameter int BCW   = 4,
   parameter int CW    = 3
) (
   input wire logic i_ref_clk,
   input wire logic i_reset_n,
   sarb_ord_if.queue q
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [IW-1:0]  id_mem [DEPTH];
   logic [BCW-1:0] bt_mem [DEPTH];
   logic [PW-1:0]  wr_ptr_r;
   logic [PW-1:0]  rd_ptr_r;
   logic [CW-1:0]  cnt_r;
   logic           do_push;
   logic           do_pop;

   assign do_push      = q.push && !q.full;
   assign do_pop       = q.pop && !q.empty;
   assign q.full       = (cnt_r == CW'(DEPTH));
   assign q.empty      = (cnt_r == '0);
   assign q.count      = cnt_r;
   assign q.head_id    = id_mem[rd_ptr_r];
   assign q.head_beats = bt_mem[rd_ptr_r];

   always_ff @(posedge i_ref_clk) begin
      if (do_push) begin
         id_mem[wr_ptr_r] <= q.push_id;
         bt_mem[wr_ptr_r] <= q.push_beats;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         cnt_r    <= '0;
      end else begin
         if (do_push) begin
            wr_ptr_r <= (wr_ptr_r == PW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (do_pop) begin
            rd_ptr_r <= (rd_ptr_r == PW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
         end
         cnt_r <= cnt_r + CW'(do_push) - CW'(do_pop);
      end
   end
endmodule : sarb_ord_fifo
`default_nettype wire

// [sarb_ord_if.sv]
// Carrier between the arbiter and its read order queue
`timescale 1ns/1ps
`default_nettype none
interface sarb_ord_if #(
   parameter int IW  = 1,
   parameter int BCW = 4,
   parameter int CW  = 3
);
   logic           push;
   logic [IW-1:0]  push_id;
   logic [BCW-1:0] push_beats;
   logic           full;
   logic           pop;
   logic [IW-1:0]  head_id;
   logic [BCW-1:0] head_beats;
   logic           empty;
   logic [CW-1:0]  count;
   modport queue (input push, push_id, push_beats, pop,
                  output full, head_id, head_beats, empty, count);
   modport user  (output push, push_id, push_beats, pop,
                  input full, head_id, head_beats, empty, count);
endinterface : sarb_ord_if
`default_nettype wire

// [sarb_pkg.sv]
// Constants shared by the shared-slave arbiter and its read tracker
`default_nettype none
package sarb_pkg;
   // *********************************************************
   // Register map
   // *********************************************************
   localparam logic [7:0] ADDR_SHARES = 8'h00;
   localparam logic [7:0] ADDR_STATUS = 8'h04;
   localparam logic [7:0] ADDR_LIMITS = 8'h08;
   localparam int         SHARE_W     = 8;
   localparam logic [7:0] SHARE_RST   = 8'h01;
   localparam int         STAT_OWNER  = 0;
   localparam int         STAT_LOCK   = 4;
   localparam int         STAT_CNT    = 8;
   localparam int         LIM_MW      = 0;
   localparam int         LIM_MR      = 8;
   localparam int         LIM_SR      = 16;
   // *********************************************************
   // Default limits
   // *********************************************************
   localparam int MW_LIMIT_DEF = 4;
   localparam int MR_LIMIT_DEF = 4;
   localparam int SR_LIMIT_DEF = 5;
   // *********************************************************
   // Arbiter phase
   // *********************************************************
   typedef enum logic {
      ST_OPEN   = 1'b0,
      ST_LOCKED = 1'b1
   } sarb_state_e;
endpackage : sarb_pkg
`default_nettype wire

// [sarb_slave_model.sv]
// Behavioural model of the shared slave with variable read latency
`timescale 1ns/1ps
`default_nettype none
module sarb_slave_model #(
   parameter int LIM = 6
) (
   // Clock and reset
   input  wire logic        i_ref_clk,
   input  wire logic        i_reset_n,
   // Read latency in cycles, two or more
   input  wire logic [3:0]  i_lat,
   // Slave port
   input  wire logic        i_read,
   input  wire logic [15:0] i_addr,
   output logic             o_waitrequest,
   output logic             o_readdatavalid,
   output logic [31:0]      o_readdata
);
   int          due_q[$];
   logic [15:0] adr_q[$];
   int          now;
   int          pend;
   // Stall once the pending limit is reached
   assign o_waitrequest = (pend >= LIM);
   always @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         due_q = {};
         adr_q = {};
         now = 0;
         pend <= 0;
         o_readdatavalid <= 1'b0;
         o_readdata <= 32'h0;
      end else begin
         now = now + 1;
         o_readdatavalid <= 1'b0;
         // Stale data is inverted every cycle, so it equals the last returned word only on alternate cycles
         o_readdata <= ~o_readdata;
         if (due_q.size() > 0 && due_q[0] <= now) begin
            o_readdatavalid <= 1'b1;
            o_readdata <= {16'hd000, adr_q[0]};
            void'(due_q.pop_front());
            void'(adr_q.pop_front());
         end
         if (i_read && !o_waitrequest) begin
            due_q.push_back(now + int'(i_lat) - 1);
            adr_q.push_back(i_addr);
         end
         pend <= due_q.size();
      end
   end
endmodule : sarb_slave_model
`default_nettype wire

// [sarb_top.sv]
// Weighted-share arbiter with pipelined read tracking for one shared slave
//
// Design decisions made here: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module sarb_top #(
   parameter int N_M     = 2,
   parameter int AW      = 16,
   parameter int DW      = 32,
   parameter int BCW     = 4,
   parameter int MW_LIM  = sarb_pkg::MW_LIMIT_DEF,
   parameter int MR_LIM  = sarb_pkg::MR_LIMIT_DEF,
   parameter int SR_LIM  = sarb_pkg::SR_LIMIT_DEF,
   parameter int FIX_LAT = 0
) (
   // Clock and reset
   input  wire logic             i_ref_clk,
   input  wire logic             i_reset_n,
   // AHB-Lite register port
   input  wire logic             i_hsel,
   input  wire logic [31:0]      i_haddr,
   input  wire logic [1:0]       i_htrans,
   input  wire logic             i_hwrite,
   input  wire logic [2:0]       i_hsize,
   input  wire logic [31:0]      i_hwdata,
   input  wire logic             i_hready,
   output logic      [31:0]      o_hrdata,
   output logic                  o_hreadyout,
   output logic                  o_hresp,
   // Master ports
   input  wire logic [N_M-1:0]     i_m_read,
   input  wire logic [N_M-1:0]     i_m_write,
   input  wire logic [N_M*AW-1:0]  i_m_addr,
   input  wire logic [N_M*DW-1:0]  i_m_wdata,
   input  wire logic [N_M*BCW-1:0] i_m_burstcount,
   output logic      [N_M-1:0]     o_m_waitrequest,
   output logic      [N_M-1:0]     o_m_readdatavalid,
   output logic      [DW-1:0]      o_m_readdata,
   // Shared slave port
   output logic                  o_s_read,
   output logic                  o_s_write,
   output logic      [AW-1:0]    o_s_addr,
   output logic      [DW-1:0]    o_s_wdata,
   output logic      [BCW-1:0]   o_s_burstcount,
   input  wire logic             i_s_waitrequest,
   input  wire logic             i_s_readdatavalid,
   input  wire logic [DW-1:0]    i_s_readdata
);
   localparam int IW     = (N_M > 1) ? $clog2(N_M) : 1;
   localparam int CW     = $clog2(SR_LIM + 1);
   localparam int RD_LIM = (MR_LIM < SR_LIM) ? MR_LIM : SR_LIM;
   localparam int LATW   = (FIX_LAT > 0) ? FIX_LAT : 1;
   localparam int SW     = sarb_pkg::SHARE_W;
   localparam logic [CW-1:0] RD_LIM_C = CW'(RD_LIM);

   // *********************************************************
   // Arbitration state
   // *********************************************************
   sarb_pkg::sarb_state_e state_r;
   logic [IW-1:0]  owner_r;
   logic [SW-1:0]  used_r;
   logic [BCW-1:0] beats_left_r;
   logic [SW-1:0]  shares_r [N_M];
   logic [CW-1:0]  cnt_r [N_M];
   logic [BCW-1:0] ret_cnt_r;
   logic [LATW-1:0] lat_sr_r;
   logic [N_M-1:0] rdv_r;
   logic [DW-1:0]  rdata_r;

   logic [N_M-1:0] req;
   logic [IW-1:0]  rr_idx;
   logic           rr_hit;
   logic [IW-1:0]  cand;
   logic [IW-1:0]  gnt_idx;
   logic [SW-1:0]  share_lim;
   logic           st_open;
   logic           fresh;
   logic           keep;
   logic [BCW-1:0] wbc;
   logic [CW-1:0]  cnt_g;
   logic           rd_ok;
   logic           acc_rd;
   logic           acc_wr;
   logic           done;
   logic           rvalid;
   logic           pop_now;

   sarb_ord_if #(.IW(IW), .BCW(BCW), .CW(CW)) ord ();

   sarb_ord_fifo #(
      .DEPTH (SR_LIM),
      .IW    (IW),
      .BCW   (BCW),
      .CW    (CW)
   ) u_ord (
      .i_ref_clk (i_ref_clk),
      .i_reset_n (i_reset_n),
      .q         (ord.queue)
   );

   assign req       = i_m_read | i_m_write;
   assign st_open   = (state_r == sarb_pkg::ST_OPEN);
   assign share_lim = (shares_r[owner_r] == '0) ? SW'(1) : shares_r[owner_r];

   // Round-robin search starting after the current owner
   always_comb begin
      rr_idx = owner_r;
      rr_hit = 1'b0;
      cand   = owner_r;
      for (int k = 1; k <= N_M; k++) begin
         cand = IW'((int'(owner_r) + k) % N_M);
         if (!rr_hit && req[cand]) begin
            rr_idx = cand;
            rr_hit = 1'b1;
         end
      end
   end

   // Owner keeps the slave while locked, while it requests with shares remaining, or while no master requests
   assign keep = !st_open
               || (req[owner_r] && used_r < share_lim)
               || !rr_hit;
   assign gnt_idx = keep ? owner_r : rr_idx;
   assign fresh   = (gnt_idx != owner_r) || (used_r >= share_lim);

   // *********************************************************
   // Slave side multiplexer
   // *********************************************************
   assign wbc   = i_m_burstcount[gnt_idx*BCW +: BCW];
   assign cnt_g = cnt_r[gnt_idx];
   assign rd_ok = st_open && !ord.full && (cnt_g < RD_LIM_C);

   assign o_s_read       = i_m_read[gnt_idx] && rd_ok;
   assign o_s_write      = i_m_write[gnt_idx];
   assign o_s_addr       = i_m_addr[gnt_idx*AW +: AW];
   assign o_s_wdata      = i_m_wdata[gnt_idx*DW +: DW];
   assign o_s_burstcount = wbc;

   assign acc_rd = o_s_read && !i_s_waitrequest;
   assign acc_wr = o_s_write && !i_s_waitrequest;

   // A share ends with a read command or the last beat of a write burst
   assign done = acc_rd
               || (acc_wr && st_open && wbc <= BCW'(1))
               || (acc_wr && !st_open && beats_left_r == BCW'(1));

   genvar gm;
   generate
      for (gm = 0; gm < N_M; gm++) begin : g_wait
         assign o_m_waitrequest[gm] = !((gnt_idx == IW'(gm))
            && ((i_m_read[gm] && rd_ok) || i_m_write[gm])
            && !i_s_waitrequest);
      end
   endgenerate

   // *********************************************************
   // Grant, share and burst lock registers
   // *********************************************************
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         state_r      <= sarb_pkg::ST_OPEN;
         owner_r      <= '0;
         used_r       <= '0;
         beats_left_r <= '0;
      end else if (st_open) begin
         if (acc_rd || acc_wr) begin
            owner_r <= gnt_idx;
            if (fresh) begin
               used_r <= done ? SW'(1) : '0;
            end else begin
               used_r <= used_r + SW'(done);
            end
         end
         if (acc_wr && wbc > BCW'(1)) begin
            state_r      <= sarb_pkg::ST_LOCKED;
            beats_left_r <= wbc - 1'b1;
         end
      end else if (acc_wr) begin
         beats_left_r <= beats_left_r - 1'b1;
         used_r       <= used_r + SW'(done);
         if (beats_left_r == BCW'(1)) begin
            state_r <= sarb_pkg::ST_OPEN;
         end
      end
   end

   // *********************************************************
   // Read return tracking
   // *********************************************************
   generate
      if (FIX_LAT > 0) begin : g_fix
         always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               lat_sr_r <= '0;
            end else begin
               lat_sr_r <= LATW'({lat_sr_r, acc_rd});
            end
         end
         assign rvalid = lat_sr_r[LATW-1];
      end else begin : g_var
         assign lat_sr_r = '0;
         assign rvalid   = i_s_readdatavalid;
      end
   endgenerate

   assign ord.push       = acc_rd;
   assign ord.push_id    = gnt_idx;
   assign ord.push_beats = (FIX_LAT > 0 || wbc == '0) ? BCW'(1) : wbc;
   assign pop_now        = rvalid && !ord.empty
                         && (ret_cnt_r + 1'b1 == ord.head_beats);
   assign ord.pop        = pop_now;

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ret_cnt_r <= '0;
      end else if (pop_now) begin
         ret_cnt_r <= '0;
      end else if (rvalid && !ord.empty) begin
         ret_cnt_r <= ret_cnt_r + 1'b1;
      end
   end

   // Per-master outstanding reads, bounded by RD_LIM, the lesser of MR_LIM and SR_LIM
   generate
      for (gm = 0; gm < N_M; gm++) begin : g_cnt
         always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               cnt_r[gm] <= '0;
            end else begin
               cnt_r[gm] <= cnt_r[gm]
                  + CW'(acc_rd && gnt_idx == IW'(gm))
                  - CW'(pop_now && ord.head_id == IW'(gm));
            end
         end
      end
   endgenerate

   // Returned words are steered to the owner of the oldest read
   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rdv_r   <= '0;
         rdata_r <= '0;
      end else begin
         rdv_r <= '0;
         if (rvalid && !ord.empty) begin
            rdv_r[ord.head_id] <= 1'b1;
            rdata_r            <= i_s_readdata;
         end
      end
   end

   assign o_m_readdatavalid = rdv_r;
   assign o_m_readdata      = rdata_r;

   // *********************************************************
   // AHB-Lite register slave
   // *********************************************************
   logic           ahb_wr_r;
   logic [7:0]     ahb_addr_r;
   logic [31:0]    hrdata_r;
   logic           ahb_start;
   logic           sh_wr;
   logic [31:0]    sh_pack;
   logic [31:0]    rd_val;

   assign ahb_start = i_hsel && i_hready && i_htrans[1];
   assign sh_wr     = ahb_wr_r && (ahb_addr_r == sarb_pkg::ADDR_SHARES);

   always_comb begin
      sh_pack = '0;
      for (int m = 0; m < N_M && m < 32 / SW; m++) begin
         sh_pack[m*SW +: SW] = sh_wr ? i_hwdata[m*SW +: SW] : shares_r[m];
      end
      rd_val = '0;
      unique case (i_haddr[7:0])
         sarb_pkg::ADDR_SHARES: rd_val = sh_pack;
         sarb_pkg::ADDR_STATUS: begin
            rd_val[sarb_pkg::STAT_OWNER +: IW] = owner_r;
            rd_val[sarb_pkg::STAT_LOCK]        = !st_open;
            rd_val[sarb_pkg::STAT_CNT +: CW]   = ord.count;
         end
         sarb_pkg::ADDR_LIMITS: begin
            rd_val[sarb_pkg::LIM_MW +: 8] = 8'(MW_LIM);
            rd_val[sarb_pkg::LIM_MR +: 8] = 8'(MR_LIM);
            rd_val[sarb_pkg::LIM_SR +: 8] = 8'(SR_LIM);
         end
         default: rd_val = '0;
      endcase
   end

   always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ahb_wr_r   <= 1'b0;
         ahb_addr_r <= '0;
         hrdata_r   <= '0;
      end else begin
         ahb_wr_r   <= ahb_start && i_hwrite;
         ahb_addr_r <= i_haddr[7:0];
         if (ahb_start && !i_hwrite) begin
            hrdata_r <= rd_val;
         end
      end
   end

   // Shares reset to one each
   generate
      for (gm = 0; gm < N_M; gm++) begin : g_shr
         always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
               shares_r[gm] <= sarb_pkg::SHARE_RST;
            end else if (sh_wr && gm < 32 / SW) begin
               shares_r[gm] <= i_hwdata[(gm % (32 / SW))*SW +: SW];
            end
         end
      end
   endgenerate

   assign o_hrdata    = hrdata_r;
   assign o_hreadyout = 1'b1;
   assign o_hresp     = 1'b0;

   // *********************************************************
   // Assertions
   // *********************************************************
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);

   property p_fix_lat;
      (FIX_LAT == 2 && acc_rd) |-> ##2 rvalid;
   endproperty
   a_fix_lat: assert property (p_fix_lat)
      else $error("fixed latency read data late or missing");

   property p_rdv_onehot;
      (rvalid && !ord.empty) |=> $onehot(o_m_readdatavalid);
   endproperty
   a_rdv_onehot: assert property (p_rdv_onehot)
      else $error("returned word not marked for exactly one master");

   property p_ord_bound;
      ord.count <= CW'(SR_LIM);
   endproperty
   a_ord_bound: assert property (p_ord_bound)
      else $error("reads in flight exceed slave read limit");

   property p_full_hold;
      (i_m_read[gnt_idx] && cnt_g == RD_LIM_C) |-> !o_s_read
         && o_m_waitrequest[gnt_idx];
   endproperty
   a_full_hold: assert property (p_full_hold)
      else $error("read passed with no free response entry");

   property p_move_grant;
      (st_open && !req[owner_r] && |req) |-> req[gnt_idx];
   endproperty
   a_move_grant: assert property (p_move_grant)
      else $error("grant idles on owner while others wait");

   property p_lock_hold;
      (state_r == sarb_pkg::ST_LOCKED) |-> gnt_idx == owner_r && !o_s_read;
   endproperty
   a_lock_hold: assert property (p_lock_hold)
      else $error("grant left a locked burst");

   property p_unlock_beat;
      (state_r == sarb_pkg::ST_OPEN && $past(state_r) ==
         sarb_pkg::ST_LOCKED) |-> $past(acc_wr) && $past(beats_left_r) == 1;
   endproperty
   a_unlock_beat: assert property (p_unlock_beat)
      else $error("burst lock released before its last beat");

   property p_share_burst;
      (!st_open && acc_wr && beats_left_r != BCW'(1)) |=>
         used_r == $past(used_r);
   endproperty
   a_share_burst: assert property (p_share_burst)
      else $error("share counted before burst end");

   property p_keep_owner;
      (st_open && req[owner_r] && used_r < share_lim) |-> ##1
         (owner_r == $past(owner_r));
   endproperty
   a_keep_owner: assert property (p_keep_owner)
      else $error("owner lost grant with shares left");

   c_lock:     cover property (state_r == sarb_pkg::ST_LOCKED ##1 st_open);
   c_pipe:     cover property (ord.count >= CW'(2));
   c_full:     cover property (i_m_read[gnt_idx] && cnt_g == RD_LIM_C);
   c_rr_moved: cover property (acc_rd && gnt_idx != owner_r);
endmodule : sarb_top
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the shared-slave arbiter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [7:0]  haddr = 8'h00;
   logic [1:0]  htrans = 2'b00;
   logic [31:0] hwdata = 32'h0, hrdata, rd, s_rdata, rdata, s_wdata;
   logic        hrdy, hresp, s_rd, s_wr, s_wait, s_rdv;
   logic [1:0]  m_read = 2'b00, m_write = 2'b00, waitreq, rdv;
   logic [31:0] m_addr = 32'h0;
   logic [63:0] m_wdata = 64'h0;
   logic [7:0]  m_bc = 8'h11;
   logic [15:0] s_addr;
   logic [3:0]  s_bc, lat = 4'h2;
   logic [31:0] ed[2][$];
   int          et[2][$];
   logic        glog[$];
   int          errors = 0, checks_done = 0, cyc = 0;
   always #25 clk = ~clk;
   sarb_top #(.MR_LIM(2), .SR_LIM(3))
   dut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_hsel(hsel),
      .i_haddr({24'h0, haddr}), .i_htrans(htrans), .i_hwrite(hwrite),
      .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hrdy),
      .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
      .i_m_read(m_read), .i_m_write(m_write), .i_m_addr(m_addr),
      .i_m_wdata(m_wdata), .i_m_burstcount(m_bc),
      .o_m_waitrequest(waitreq), .o_m_readdatavalid(rdv),
      .o_m_readdata(rdata), .o_s_read(s_rd), .o_s_write(s_wr),
      .o_s_addr(s_addr), .o_s_wdata(s_wdata), .o_s_burstcount(s_bc),
      .i_s_waitrequest(s_wait), .i_s_readdatavalid(s_rdv),
      .i_s_readdata(s_rdata));
   sarb_slave_model #(.LIM(6)) slave (.i_ref_clk(clk), .i_reset_n(rst_n),
      .i_lat(lat), .i_read(s_rd), .i_addr(s_addr), .o_waitrequest(s_wait),
      .o_readdatavalid(s_rdv), .o_readdata(s_rdata));
   // ***********************************************
   // Monitor: grant order, read data and latency
   // ***********************************************
   always @(posedge clk) begin
      cyc++;
      for (int i = 0; i < 2; i++) begin
         if ((m_read[i] | m_write[i]) && waitreq[i] === 1'b0) begin
            glog.push_back(i[0]);
            if (m_write[i]) begin
               chk(s_wdata, {16'h5a00, m_addr[i*16 +: 16]});
               chk(32'({s_wr, s_bc}), 32'({1'b1, m_bc[i*4 +: 4]}));
            end
            if (m_read[i]) begin
               ed[i].push_back({16'hd000, m_addr[i*16 +: 16]});
               et[i].push_back(cyc + int'(lat) + 1);
            end
         end
         if (rdv[i] === 1'b1) begin
            chk(32'(ed[i].size() > 0), 32'h1);
            chk(rdata, ed[i].pop_front());
            chk(32'(cyc), 32'(et[i].pop_front()));
         end
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wrap_up();
      $display("Checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : wrap_up
   task automatic wait_ok(input int m);
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while ((m == 2 ? hrdy : !waitreq[m]) !== 1'b1 && n < 200);
      if (n >= 200) begin
         errors++;
         wrap_up();
      end
   endtask : wait_ok
   task automatic ahb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= wr;
      wait_ok(2);
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ok(2);
      r = hrdata;
   endtask : ahb
   task automatic mop(input int m, input logic r, input logic [15:0] a,
                      input logic [3:0] bc);
      m_read[m] <= r;
      m_write[m] <= !r;
      m_addr[m*16 +: 16] <= a;
      m_wdata[m*32 +: 32] <= {16'h5a00, a};
      m_bc[m*4 +: 4] <= bc;
      wait_ok(m);
   endtask : mop
   task automatic mrel(input int m);
      m_read[m] <= 1'b0;
      m_write[m] <= 1'b0;
      @(posedge clk);
   endtask : mrel
   task automatic drain();
      int n;
      n = 0;
      while (ed[0].size() + ed[1].size() != 0 && n < 100) begin
         @(posedge clk);
         n++;
      end
      chk(32'(n < 100), 32'h1);
   endtask : drain
   task automatic arb(input logic [31:0] sh, input int n0, input int n1,
                      input logic [7:0] exp);
      logic [7:0] got;
      got = 8'h00;
      ahb(1'b1, 8'h00, sh, rd);
      glog = {};
      fork
         begin
            for (int k = 0; k < n0; k++) mop(0, 1'b0, 16'(k), 4'h1);
            mrel(0);
         end
         begin
            @(posedge clk);
            for (int k = 0; k < n1; k++) mop(1, 1'b0, 16'(k), 4'h1);
            mrel(1);
         end
      join
      foreach (glog[k]) got[k] = glog[k];
      chk(32'(glog.size()), 32'(n0 + n1));
      chk(32'(got), 32'(exp));
   endtask : arb
   initial begin
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      ahb(1'b0, 8'h00, 32'h0, rd);
      chk(rd & 32'h0000ffff, 32'h00000101);
      ahb(1'b1, 8'h08, 32'hffffffff, rd);
      ahb(1'b0, 8'h08, 32'h0, rd);
      chk(rd, 32'h00030204);
      ahb(1'b0, 8'h0c, 32'h0, rd);
      chk(rd, 32'h0);
      chk(32'(hresp), 32'h0);
      arb(32'h00000101, 3, 3, 8'h2a);
      arb(32'h00000102, 4, 3, 8'h64);
      glog = {};
      mop(0, 1'b0, 16'h0200, 4'h3);
      fork
         begin
            mop(1, 1'b0, 16'h0300, 4'h1);
            mrel(1);
         end
         begin
            mrel(0);
            ahb(1'b0, 8'h04, 32'h0, rd);
            chk(rd, 32'h00000010);
            @(posedge clk);
            chk(32'(waitreq[1]), 32'h1);
            mop(0, 1'b0, 16'h0201, 4'h3);
            mop(0, 1'b0, 16'h0202, 4'h3);
            mrel(0);
         end
      join
      chk(32'({glog[3], glog[2], glog[1], glog[0]}), 32'h8);
      fork
         begin
            mop(0, 1'b1, 16'h0400, 4'h1);
            mop(0, 1'b1, 16'h0401, 4'h1);
            mrel(0);
         end
         begin
            mop(1, 1'b1, 16'h0500, 4'h1);
            mop(1, 1'b1, 16'h0501, 4'h1);
            mrel(1);
         end
      join
      drain();
      lat <= 4'h6;
      mop(0, 1'b1, 16'h0600, 4'h1);
      mop(0, 1'b1, 16'h0601, 4'h1);
      fork
         begin
            mop(0, 1'b1, 16'h0602, 4'h1);
            mrel(0);
         end
         begin
            mop(1, 1'b1, 16'h0700, 4'h1);
            mop(1, 1'b1, 16'h0701, 4'h1);
            mrel(1);
         end
         begin
            repeat (3) @(posedge clk);
            chk(32'(waitreq[0]), 32'h1);
            chk(32'(waitreq[1]), 32'h1);
         end
      join
      drain();
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
